/* verilog/svl_pkg.sv */
package svl_pkg;

  // ****************************************
  // lane and register geometry
  // ****************************************
  localparam int LANE_W = 32;
  localparam int LANES = 4;
  localparam int VEC_W = 128;
  localparam int HALF_W = 64;
  localparam int NUM_VREG = 8;
  localparam int VIDX_W = 3;
  localparam int EXP_W = 8;
  localparam int FRAC_W = 23;
  localparam int SIGNIF_W = 24;
  localparam int ADDR_W = 32;
  localparam int BE_W = 16;

  // ****************************************
  // control/status field positions and values
  // ****************************************
  localparam int CS_W = 32;
  localparam int CS_FLAG_DEN = 1;
  localparam int CS_DAZ = 6;
  localparam int CS_MASK_DEN = 8;
  localparam logic [31:0] CS_RESET = 32'h0000_1F80;
  localparam logic [31:0] CS_RSV_BITS = 32'hFFFF_0000;
  localparam logic [31:0] CS_DAZ_BIT = 32'h0000_0040;
  localparam logic [31:0] CS_WMASK_DAZ = 32'h0000_FFFF;
  localparam logic [31:0] CS_WMASK_NODAZ = 32'h0000_FFBF;

  // ****************************************
  // memory operand shapes
  // ****************************************
  localparam logic [3:0] ALIGN_MASK = 4'hF;
  localparam logic [15:0] BE_FULL = 16'hFFFF;
  localparam logic [15:0] BE_QUAD = 16'h00FF;
  localparam logic [15:0] BE_DWORD = 16'h000F;

  // ****************************************
  // bus register map
  // ****************************************
  localparam logic [7:0] ADR_CS = 8'h00;
  localparam logic [7:0] ADR_WMASK = 8'h04;
  localparam logic [7:0] ADR_FAULT = 8'h08;
  localparam int ADR_VREG_BIT = 7;
  localparam int FLT_GP = 0;
  localparam int FLT_SIMD = 1;
  localparam int FLT_BUS = 2;
  localparam int FLT_W = 3;

  typedef enum logic [3:0] {
    OP_ALIGNED_MOVE = 4'h0,
    OP_UNALIGNED_MOVE = 4'h1,
    OP_SCALAR_MOVE = 4'h2,
    OP_LOW_HALF_MOVE = 4'h3,
    OP_HIGH_HALF_MOVE = 4'h4,
    OP_LOW_TO_HIGH = 4'h5,
    OP_HIGH_TO_LOW = 4'h6,
    OP_SIGN_MASK = 4'h7,
    OP_PACKED = 4'h8,
    OP_SCALAR = 4'h9,
    OP_CS_LOAD = 4'hA,
    OP_CS_STORE = 4'hB
  } svl_op_type;

  typedef enum logic [2:0] {
    FN_AND = 3'h0,
    FN_ANDN = 3'h1,
    FN_OR = 3'h2,
    FN_XOR = 3'h3,
    FN_MIN = 3'h4,
    FN_MAX = 3'h5
  } svl_fn_type;

endpackage

/* verilog/svl_lane_prep.sv */
module svl_lane_prep (
  input wire logic [svl_pkg::LANE_W-1:0] lane_i,
  input wire logic daz_i,
  output logic [svl_pkg::LANE_W-1:0] lane_o,
  output logic denormal_o
);

  logic [svl_pkg::EXP_W-1:0] exp_f;
  logic [svl_pkg::FRAC_W-1:0] frac_f;

  assign exp_f = lane_i[svl_pkg::LANE_W-2 -: svl_pkg::EXP_W];
  assign frac_f = lane_i[svl_pkg::FRAC_W-1:0];
  assign denormal_o = (exp_f == '0) && (frac_f != '0);
  // sign survives so the zero keeps its polarity
  assign lane_o = (daz_i && denormal_o) ?
    {lane_i[svl_pkg::LANE_W-1], {(svl_pkg::LANE_W-1){1'b0}}} : lane_i;

endmodule

/* verilog/svl_datapath.sv */
// Operation
// - with zero-denormal mode on, denormal sources become signed zero first
// - zero-denormal mode never sets denormal flag nor raises denormal fault
// - zero-denormal enable is cleared at reset
// - without zero-denormal support, setting bit 6 is a protection fault
// - one vector register file and one control word for all generations
// - vector registers are separate from other register files
// - a 128-bit operand is four independent 32-bit single values
// - packed memory operands need 16-byte alignment; unaligned and scalar exempt
// - packed ops work on all four lane pairs in parallel
// - scalar ops compute lane 0 and pass upper lanes of source one
// - results keep 24-bit significand and 8-bit exponent format
// - aligned move moves four lanes, faults on misaligned address
// - unaligned move moves four lanes at any address
// - scalar move moves one 32-bit value to or from lane 0
// - low-half move moves low 64 bits, high half untouched
// - high-half move moves high 64 bits, low half untouched
// - low-to-high move copies source low half into destination high half
// - high-to-low move copies source high half into destination low half
// - sign-mask gathers four lane sign bits into a 4-bit value
// - control bits 16..31 stay zero; nonzero load is a protection fault
// - all six exception masks are set at reset
module svl_datapath #(
  parameter bit DAZ_SUPPORTED = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic issue_valid_i,
  output logic issue_ready_o,
  input wire svl_pkg::svl_op_type issue_op_i,
  input wire svl_pkg::svl_fn_type issue_fn_i,
  input wire logic [svl_pkg::VIDX_W-1:0] issue_dst_i,
  input wire logic [svl_pkg::VIDX_W-1:0] issue_src_i,
  input wire logic issue_mem_i,
  input wire logic issue_store_i,
  input wire logic [svl_pkg::ADDR_W-1:0] issue_addr_i,
  input wire logic [svl_pkg::VEC_W-1:0] issue_mem_data_i,
  output logic done_o,
  output logic gp_fault_o,
  output logic simd_fault_o,
  output logic mem_wr_o,
  output logic [svl_pkg::ADDR_W-1:0] mem_addr_o,
  output logic [svl_pkg::VEC_W-1:0] mem_wdata_o,
  output logic [svl_pkg::BE_W-1:0] mem_be_o,
  output logic gpr_wr_o,
  output logic [31:0] gpr_data_o,
  output logic [svl_pkg::CS_W-1:0] ctl_status_o
);

  localparam int LW = svl_pkg::LANE_W;
  localparam int HW = svl_pkg::HALF_W;
  localparam logic [31:0] WMASK = DAZ_SUPPORTED ?
    svl_pkg::CS_WMASK_DAZ : svl_pkg::CS_WMASK_NODAZ;

  // ****************************************
  // state
  // ****************************************
  logic [svl_pkg::VEC_W-1:0] vreg_q [svl_pkg::NUM_VREG];
  logic [svl_pkg::CS_W-1:0] cs_q;
  logic [svl_pkg::FLT_W-1:0] fault_q;
  logic ack_q;
  logic [31:0] rdat_q;

  logic fire;
  logic denormals_as_zero_enable;
  logic [svl_pkg::VEC_W-1:0] src1;
  logic [svl_pkg::VEC_W-1:0] src2;
  logic [svl_pkg::VEC_W-1:0] vsrc;
  logic [svl_pkg::VEC_W-1:0] op_a;
  logic [svl_pkg::VEC_W-1:0] op_b;
  logic [svl_pkg::VEC_W-1:0] res;
  logic [svl_pkg::LANES-1:0] den_a;
  logic [svl_pkg::LANES-1:0] den_b;
  logic misaligned;

  logic [svl_pkg::VEC_W-1:0] nxt_vec;
  logic wr_vec;
  logic gp_d;
  logic simd_d;
  logic den_evt;
  logic mwr_d;
  logic [svl_pkg::VEC_W-1:0] mwd_d;
  logic [svl_pkg::BE_W-1:0] mbe_d;
  logic gwr_d;
  logic [31:0] gdat_d;
  logic cs_load;

  logic bus_req;
  logic bus_wr;
  logic bus_cs_wr;
  logic bus_cs_bad;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic cs_illegal(input logic [31:0] v);
    logic bad;
    bad = (v & svl_pkg::CS_RSV_BITS) != 32'h0000_0000;
    if (!DAZ_SUPPORTED && ((v & svl_pkg::CS_DAZ_BIT) != 32'h0000_0000)) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  // sign-magnitude order; nan ordering is not modelled
  function automatic logic fp_less(input logic [31:0] a, input logic [31:0] b);
    logic lt;
    if (a[LW-1] != b[LW-1]) begin
      lt = a[LW-1] && ((a[LW-2:0] | b[LW-2:0]) != '0);
    end else if (a[LW-1]) begin
      lt = a[LW-2:0] > b[LW-2:0];
    end else begin
      lt = a[LW-2:0] < b[LW-2:0];
    end
    return lt;
  endfunction

  // results are always whole single-width lanes: 1 sign, 8 exponent, 23 fraction
  function automatic logic [31:0] lane_op(
    input svl_pkg::svl_fn_type fn,
    input logic [31:0] a,
    input logic [31:0] b
  );
    logic [31:0] r;
    case (fn)
      svl_pkg::FN_AND: r = a & b;
      svl_pkg::FN_ANDN: r = ~a & b;
      svl_pkg::FN_OR: r = a | b;
      svl_pkg::FN_XOR: r = a ^ b;
      svl_pkg::FN_MIN: r = fp_less(a, b) ? a : b;
      svl_pkg::FN_MAX: r = fp_less(b, a) ? a : b;
      default: r = a;
    endcase
    return r;
  endfunction

  // ****************************************
  // operand fetch and lane preparation
  // ****************************************
  assign issue_ready_o = !rst_i;
  assign fire = issue_valid_i && !rst_i;
  assign denormals_as_zero_enable = cs_q[svl_pkg::CS_DAZ];
  assign src1 = vreg_q[issue_dst_i];
  assign vsrc = vreg_q[issue_src_i];
  assign src2 = issue_mem_i ? issue_mem_data_i : vsrc;
  assign misaligned = issue_mem_i && ((issue_addr_i[3:0] & svl_pkg::ALIGN_MASK) != 4'h0);

  generate
    for (genvar i = 0; i < svl_pkg::LANES; i++) begin : g_lane
      svl_lane_prep u_prep_a (
        .lane_i(src1[i*LW +: LW]),
        .daz_i(denormals_as_zero_enable),
        .lane_o(op_a[i*LW +: LW]),
        .denormal_o(den_a[i])
      );
      svl_lane_prep u_prep_b (
        .lane_i(src2[i*LW +: LW]),
        .daz_i(denormals_as_zero_enable),
        .lane_o(op_b[i*LW +: LW]),
        .denormal_o(den_b[i])
      );
      assign res[i*LW +: LW] = lane_op(issue_fn_i, op_a[i*LW +: LW], op_b[i*LW +: LW]);
    end
  endgenerate

  // ****************************************
  // execute decision
  // ****************************************
  always_comb begin
    nxt_vec = src1;
    wr_vec = 1'b0;
    gp_d = 1'b0;
    simd_d = 1'b0;
    den_evt = 1'b0;
    mwr_d = 1'b0;
    mwd_d = '0;
    mbe_d = '0;
    gwr_d = 1'b0;
    gdat_d = 32'h0000_0000;
    cs_load = 1'b0;
    case (issue_op_i)
      svl_pkg::OP_ALIGNED_MOVE, svl_pkg::OP_UNALIGNED_MOVE: begin
        if (issue_op_i == svl_pkg::OP_ALIGNED_MOVE && misaligned) begin
          gp_d = 1'b1;
        end else if (issue_mem_i && issue_store_i) begin
          mwr_d = 1'b1;
          mwd_d = vsrc;
          mbe_d = svl_pkg::BE_FULL;
        end else begin
          nxt_vec = src2;
          wr_vec = 1'b1;
        end
      end
      svl_pkg::OP_SCALAR_MOVE: begin
        if (issue_mem_i && issue_store_i) begin
          mwr_d = 1'b1;
          mwd_d = {{(svl_pkg::VEC_W-LW){1'b0}}, vsrc[LW-1:0]};
          mbe_d = svl_pkg::BE_DWORD;
        end else begin
          nxt_vec = {src1[svl_pkg::VEC_W-1:LW], src2[LW-1:0]};
          wr_vec = 1'b1;
        end
      end
      svl_pkg::OP_LOW_HALF_MOVE: begin
        if (issue_store_i) begin
          mwr_d = 1'b1;
          mwd_d = {{HW{1'b0}}, vsrc[HW-1:0]};
          mbe_d = svl_pkg::BE_QUAD;
        end else begin
          nxt_vec = {src1[svl_pkg::VEC_W-1:HW], issue_mem_data_i[HW-1:0]};
          wr_vec = 1'b1;
        end
      end
      svl_pkg::OP_HIGH_HALF_MOVE: begin
        if (issue_store_i) begin
          mwr_d = 1'b1;
          mwd_d = {{HW{1'b0}}, vsrc[svl_pkg::VEC_W-1:HW]};
          mbe_d = svl_pkg::BE_QUAD;
        end else begin
          nxt_vec = {issue_mem_data_i[HW-1:0], src1[HW-1:0]};
          wr_vec = 1'b1;
        end
      end
      svl_pkg::OP_LOW_TO_HIGH: begin
        nxt_vec = {vsrc[HW-1:0], src1[HW-1:0]};
        wr_vec = 1'b1;
      end
      svl_pkg::OP_HIGH_TO_LOW: begin
        nxt_vec = {src1[svl_pkg::VEC_W-1:HW], vsrc[svl_pkg::VEC_W-1:HW]};
        wr_vec = 1'b1;
      end
      svl_pkg::OP_SIGN_MASK: begin
        gwr_d = 1'b1;
        gdat_d = {28'h000_0000, vsrc[127], vsrc[95], vsrc[63], vsrc[31]};
      end
      svl_pkg::OP_PACKED, svl_pkg::OP_SCALAR: begin
        if (issue_op_i == svl_pkg::OP_PACKED) begin
          gp_d = misaligned;
          den_evt = !denormals_as_zero_enable && ((den_a | den_b) != '0);
          nxt_vec = res;
        end else begin
          den_evt = !denormals_as_zero_enable && (den_a[0] || den_b[0]);
          nxt_vec = {src1[svl_pkg::VEC_W-1:LW], res[LW-1:0]};
        end
        // an unmasked denormal leaves the destination alone
        simd_d = !gp_d && den_evt && !cs_q[svl_pkg::CS_MASK_DEN];
        wr_vec = !gp_d && !simd_d;
        den_evt = den_evt && !gp_d;
      end
      svl_pkg::OP_CS_LOAD: begin
        gp_d = cs_illegal(issue_mem_data_i[31:0]);
        cs_load = !gp_d;
      end
      svl_pkg::OP_CS_STORE: begin
        mwr_d = 1'b1;
        mwd_d = {96'h0, cs_q};
        mbe_d = svl_pkg::BE_DWORD;
      end
      default: begin
        gp_d = 1'b1;
      end
    endcase
  end

  // ****************************************
  // vector register file
  // ****************************************
  // one file for every instruction generation, not aliased to other register sets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int r = 0; r < svl_pkg::NUM_VREG; r++) begin
        vreg_q[r] <= '0;
      end
    end else if (fire && wr_vec) begin
      vreg_q[issue_dst_i] <= nxt_vec;
    end
  end

  // ****************************************
  // control/status word
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_q <= svl_pkg::CS_RESET;
    end else begin
      if (fire && cs_load) begin
        cs_q <= issue_mem_data_i[31:0];
      end else if (bus_cs_wr && !bus_cs_bad) begin
        cs_q <= wb_dat_i;
      end
      // sticky flag: a new event beats a clear in the same cycle
      if (fire && den_evt) begin
        cs_q[svl_pkg::CS_FLAG_DEN] <= 1'b1;
      end
    end
  end

  // ****************************************
  // result outputs
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      gp_fault_o <= 1'b0;
      simd_fault_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= '0;
      mem_be_o <= '0;
      gpr_wr_o <= 1'b0;
      gpr_data_o <= 32'h0000_0000;
    end else begin
      done_o <= fire;
      gp_fault_o <= fire && gp_d;
      simd_fault_o <= fire && simd_d;
      mem_wr_o <= fire && mwr_d;
      mem_addr_o <= issue_addr_i;
      mem_wdata_o <= mwd_d;
      mem_be_o <= (fire && mwr_d) ? mbe_d : '0;
      gpr_wr_o <= fire && gwr_d;
      gpr_data_o <= gdat_d;
    end
  end

  assign ctl_status_o = cs_q;

  // ****************************************
  // wishbone slave
  // ****************************************
  assign bus_req = wb_cyc_i && wb_stb_i;
  // writes land on the edge that the master sees ack
  assign bus_wr = bus_req && ack_q && wb_we_i;
  assign bus_cs_wr = bus_wr && (wb_adr_i == svl_pkg::ADR_CS) && (wb_sel_i == 4'hF);
  assign bus_cs_bad = cs_illegal(wb_dat_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (bus_req && !ack_q) begin
      if (wb_adr_i[svl_pkg::ADR_VREG_BIT]) begin
        rdat_q <= vreg_q[wb_adr_i[6:4]][wb_adr_i[3:2]*LW +: LW];
      end else begin
        case (wb_adr_i)
          svl_pkg::ADR_CS: rdat_q <= cs_q;
          svl_pkg::ADR_WMASK: rdat_q <= WMASK;
          svl_pkg::ADR_FAULT: rdat_q <= {29'h0, fault_q};
          default: rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sticky fault record, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= '0;
    end else begin
      if (bus_wr && wb_adr_i == svl_pkg::ADR_FAULT && wb_sel_i[0]) begin
        fault_q <= fault_q & ~wb_dat_i[svl_pkg::FLT_W-1:0];
      end
      if (fire && gp_d) begin
        fault_q[svl_pkg::FLT_GP] <= 1'b1;
      end
      if (fire && simd_d) begin
        fault_q[svl_pkg::FLT_SIMD] <= 1'b1;
      end
      if (bus_cs_wr && bus_cs_bad) begin
        fault_q[svl_pkg::FLT_BUS] <= 1'b1;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule

/* testbench/svl_mem_model.sv */
module svl_mem_model (
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [31:0] addr_i,
  input wire logic wr_i,
  input wire logic [31:0] waddr_i,
  input wire logic [127:0] wdata_i,
  input wire logic [15:0] be_i,
  output logic [127:0] rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem_q [256];
  // ****************************************
  // byte memory, lane0 of 0xC0 is a denormal
  // ****************************************
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_q[i] = 8'(i) ^ 8'hA5;
    end
    mem_q[8'hC0] = 8'h01;
    mem_q[8'hC1] = 8'h00;
    mem_q[8'hC2] = 8'h00;
    mem_q[8'hC3] = 8'h00;
  end
  // data not qualified by valid is inverted so a stale capture shows up
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      rdata_o[8*i +: 8] = valid_i ? mem_q[8'(addr_i + i)] : ~mem_q[8'(addr_i + i)];
    end
  end
  always @(posedge clk_i) begin
    for (int i = 0; i < 16; i++) begin
      if (wr_i && be_i[i]) begin
        mem_q[8'(waddr_i + i)] <= wdata_i[8*i +: 8];
      end
    end
  end
endmodule

/* testbench/svl_datapath_chk.sv */
module svl_datapath_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic issue_valid_i,
  input wire svl_pkg::svl_op_type issue_op_i,
  input wire logic issue_mem_i,
  input wire logic issue_store_i,
  input wire logic [31:0] issue_addr_i,
  input wire logic done_o,
  input wire logic gp_fault_o,
  input wire logic simd_fault_o,
  input wire logic mem_wr_o,
  input wire logic [15:0] mem_be_o,
  input wire logic gpr_wr_o,
  input wire logic [31:0] gpr_data_o,
  input wire logic [31:0] ctl_status_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_done;
    issue_valid_i |=> done_o;
  endproperty
  a_done: assert property (p_done) else $error("no done after issue");
  property p_idle;
    !issue_valid_i |=> !done_o && !mem_wr_o && !gpr_wr_o;
  endproperty
  a_idle: assert property (p_idle) else $error("output without issue");
  property p_align;
    issue_valid_i && issue_mem_i && issue_addr_i[3:0] != 4'h0 &&
      (issue_op_i == svl_pkg::OP_ALIGNED_MOVE || issue_op_i == svl_pkg::OP_PACKED) |=> gp_fault_o;
  endproperty
  a_align: assert property (p_align) else $error("misaligned not faulted");
  property p_unal;
    issue_valid_i && issue_op_i == svl_pkg::OP_UNALIGNED_MOVE |=> !gp_fault_o;
  endproperty
  a_unal: assert property (p_unal) else $error("unaligned move faulted");
  property p_quiet;
    gp_fault_o |-> !mem_wr_o && !gpr_wr_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("faulting op wrote");
  property p_daz;
    issue_valid_i && ctl_status_o[svl_pkg::CS_DAZ] && !wb_ack_o && issue_op_i == svl_pkg::OP_PACKED
      |=> !simd_fault_o && !$rose(ctl_status_o[svl_pkg::CS_FLAG_DEN]);
  endproperty
  a_daz: assert property (p_daz) else $error("denormal event in zero mode");
  property p_rsv;
    ctl_status_o[31:16] == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bits set");
  property p_rst;
    $past(rst_i) |-> ctl_status_o == svl_pkg::CS_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("bad control word after reset");
  property p_mask;
    issue_valid_i && issue_op_i == svl_pkg::OP_SIGN_MASK |=> gpr_wr_o && gpr_data_o[31:4] == 28'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("sign mask malformed");
  property p_half;
    issue_valid_i && issue_op_i == svl_pkg::OP_LOW_HALF_MOVE && issue_store_i
      |=> mem_wr_o && mem_be_o == svl_pkg::BE_QUAD;
  endproperty
  a_half: assert property (p_half) else $error("half store bad strobes");
  c_gp: cover property (gp_fault_o);
  c_gpr: cover property (gpr_wr_o);
  c_daz: cover property (issue_valid_i && ctl_status_o[svl_pkg::CS_DAZ]);
  c_simd: cover property (simd_fault_o);
endmodule

bind svl_datapath svl_datapath_chk svl_datapath_chk_inst (.clk_i, .rst_i, .wb_ack_o,
  .issue_valid_i, .issue_op_i, .issue_mem_i, .issue_store_i, .issue_addr_i, .done_o,
  .gp_fault_o, .simd_fault_o, .mem_wr_o, .mem_be_o, .gpr_wr_o, .gpr_data_o, .ctl_status_o);

/* testbench/svl_datapath_tb.sv */
module svl_datapath_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, issue_valid_i, issue_ready_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, issue_addr_i, mem_addr_o, gpr_data_o, ctl_status_o, q;
  svl_pkg::svl_op_type issue_op_i;
  svl_pkg::svl_fn_type issue_fn_i;
  logic [2:0] issue_dst_i, issue_src_i;
  logic issue_mem_i, issue_store_i, done_o, gp_fault_o, simd_fault_o, mem_wr_o, gpr_wr_o;
  logic [127:0] issue_mem_data_i, mem_wdata_o, e1, e2, v;
  logic [15:0] mem_be_o;
  int fail_count, num_checks;
  svl_datapath svl_datapath_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .issue_valid_i, .issue_ready_o, .issue_op_i,
    .issue_fn_i, .issue_dst_i, .issue_src_i, .issue_mem_i, .issue_store_i, .issue_addr_i,
    .issue_mem_data_i, .done_o, .gp_fault_o, .simd_fault_o, .mem_wr_o, .mem_addr_o,
    .mem_wdata_o, .mem_be_o, .gpr_wr_o, .gpr_data_o, .ctl_status_o);
  svl_mem_model svl_mem_model_inst (.clk_i, .valid_i(issue_valid_i), .addr_i(issue_addr_i),
    .wr_i(mem_wr_o), .waddr_i(mem_addr_o), .wdata_i(mem_wdata_o), .be_i(mem_be_o),
    .rdata_o(issue_mem_data_i));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [127:0] pat(input logic [7:0] a);
    for (int i = 0; i < 16; i++) begin
      pat[8*i +: 8] = 8'(a + i) ^ 8'hA5;
    end
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // ack and read data are taken at the rising edge, request held until then
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (wb_ack_o !== 1'h1) begin
      fail_count++;
      summarize();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rdv(input logic [2:0] r);
    for (int i = 0; i < 4; i++) begin
      wb(1'h0, {1'h1, r, 2'(i), 2'h0}, 32'h0);
      v[32*i +: 32] = q;
    end
  endtask
  task automatic iss(input svl_pkg::svl_op_type op, input logic [2:0] d, input logic [2:0] s,
      input logic [1:0] mw, input logic [31:0] a,
      input svl_pkg::svl_fn_type fn = svl_pkg::FN_AND, input logic g = 1'h0);
    @(posedge clk_i);
    issue_valid_i <= 1'h1;
    issue_op_i <= op;
    issue_fn_i <= fn;
    issue_dst_i <= d;
    issue_src_i <= s;
    {issue_mem_i, issue_store_i} <= mw;
    issue_addr_i <= a;
    @(posedge clk_i);
    issue_valid_i <= 1'h0;
    @(negedge clk_i);
    chk({done_o, gp_fault_o}, {1'h1, g}, "done or fault");
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    wb(1'h0, svl_pkg::ADR_CS, 32'h0);
    chk(q, 32'h0000_1F80, "ctl reset");
    wb(1'h0, svl_pkg::ADR_WMASK, 32'h0);
    chk(q, 32'h0000_FFFF, "wmask");
    wb(1'h0, 8'h0C, 32'h0);
    chk(q, 32'h0, "unmapped");
  endtask
  task automatic t_moves();
    iss(svl_pkg::OP_ALIGNED_MOVE, 3'h1, 3'h0, 2'h2, 32'h10);
    e1 = pat(8'h10);
    iss(svl_pkg::OP_ALIGNED_MOVE, 3'h2, 3'h0, 2'h2, 32'h14, svl_pkg::FN_AND, 1'h1);
    iss(svl_pkg::OP_PACKED, 3'h1, 3'h1, 2'h2, 32'h18, svl_pkg::FN_AND, 1'h1);
    rdv(3'h1);
    chk(v, e1, "aligned load");
    rdv(3'h2);
    chk(v, 128'h0, "faulted load wrote");
    iss(svl_pkg::OP_UNALIGNED_MOVE, 3'h2, 3'h0, 2'h2, 32'h24);
    e2 = pat(8'h24);
    iss(svl_pkg::OP_LOW_HALF_MOVE, 3'h1, 3'h0, 2'h2, 32'h40);
    e1[63:0] = pat(8'h40) >> 0;
    iss(svl_pkg::OP_HIGH_HALF_MOVE, 3'h2, 3'h0, 2'h2, 32'h50);
    e2[127:64] = pat(8'h50) >> 0;
    rdv(3'h1);
    chk(v, e1, "low half");
    rdv(3'h2);
    chk(v, e2, "high half");
    iss(svl_pkg::OP_LOW_TO_HIGH, 3'h1, 3'h2, 2'h0, 32'h0);
    e1[127:64] = e2[63:0];
    iss(svl_pkg::OP_HIGH_TO_LOW, 3'h2, 3'h1, 2'h0, 32'h0);
    e2[63:0] = e1[127:64];
    iss(svl_pkg::OP_SCALAR_MOVE, 3'h2, 3'h0, 2'h2, 32'h61);
    e2[31:0] = pat(8'h61) >> 0;
    rdv(3'h1);
    chk(v, e1, "low to high");
    rdv(3'h2);
    chk(v, e2, "high to low, scalar");
    iss(svl_pkg::OP_SIGN_MASK, 3'h1, 3'h1, 2'h0, 32'h0);
    chk(gpr_data_o[3:0], {e1[127], e1[95], e1[63], e1[31]}, "sign mask");
    iss(svl_pkg::OP_ALIGNED_MOVE, 3'h0, 3'h1, 2'h3, 32'hE0);
    chk({mem_wr_o, mem_be_o, mem_addr_o, mem_wdata_o}, {1'h1, 16'hFFFF, 32'hE0, e1}, "st");
  endtask
  task automatic t_arith();
    iss(svl_pkg::OP_PACKED, 3'h1, 3'h2, 2'h0, 32'h0, svl_pkg::FN_XOR);
    e1 = e1 ^ e2;
    iss(svl_pkg::OP_SCALAR, 3'h2, 3'h1, 2'h0, 32'h0, svl_pkg::FN_OR);
    e2[31:0] = e2[31:0] | e1[31:0];
    rdv(3'h1);
    chk(v, e1, "packed xor");
    rdv(3'h2);
    chk(v, e2, "scalar or");
  endtask
  task automatic t_daz();
    iss(svl_pkg::OP_ALIGNED_MOVE, 3'h3, 3'h0, 2'h2, 32'hC0);
    iss(svl_pkg::OP_PACKED, 3'h3, 3'h3, 2'h0, 32'h0, svl_pkg::FN_OR);
    chk(ctl_status_o[svl_pkg::CS_FLAG_DEN], 1'h1, "denormal flag");
    rdv(3'h3);
    chk(v[31:0], 32'h1, "denormal kept");
    // zero mode on with the denormal fault unmasked
    wb(1'h1, svl_pkg::ADR_CS, 32'h0000_1EC0);
    iss(svl_pkg::OP_PACKED, 3'h3, 3'h3, 2'h0, 32'h0, svl_pkg::FN_OR);
    chk({simd_fault_o, ctl_status_o}, {1'h0, 32'h0000_1EC0}, "no denormal event");
    rdv(3'h3);
    chk(v[31:0], 32'h0, "denormal zeroed");
    iss(svl_pkg::OP_CS_LOAD, 3'h0, 3'h0, 2'h2, 32'hC4, svl_pkg::FN_AND, 1'h1);
    chk(ctl_status_o, 32'h0000_1EC0, "faulted load");
    wb(1'h1, svl_pkg::ADR_CS, 32'h0001_1F80);
    wb(1'h0, svl_pkg::ADR_CS, 32'h0);
    chk(q, 32'h0000_1EC0, "reserved write");
    wb(1'h0, svl_pkg::ADR_FAULT, 32'h0);
    chk(q[svl_pkg::FLT_BUS], 1'h1, "refused write");
    // zero mode off, denormal fault unmasked: fault, flag, no write
    wb(1'h1, svl_pkg::ADR_CS, 32'h0000_1E80);
    iss(svl_pkg::OP_ALIGNED_MOVE, 3'h3, 3'h0, 2'h2, 32'hC0);
    iss(svl_pkg::OP_PACKED, 3'h4, 3'h3, 2'h0, 32'h0, svl_pkg::FN_OR);
    chk({simd_fault_o, ctl_status_o}, {1'h1, 32'h0000_1E82}, "unmasked denormal");
    rdv(3'h4);
    chk(v, 128'h0, "faulted op wrote");
  endtask
  task automatic t_rerst();
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(issue_ready_o, 1'h0, "ready in reset");
    @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, svl_pkg::ADR_CS, 32'h0);
    chk(q, 32'h0000_1F80, "ctl after reset");
    wb(1'h0, svl_pkg::ADR_FAULT, 32'h0);
    chk(q, 32'h0, "faults after reset");
    chk(issue_ready_o, 1'h1, "ready after reset");
  endtask
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, issue_valid_i, issue_mem_i, issue_store_i} = 6'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    issue_op_i = svl_pkg::OP_ALIGNED_MOVE;
    issue_fn_i = svl_pkg::FN_AND;
    {issue_dst_i, issue_src_i} = 6'h00;
    issue_addr_i = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_moves();
    t_arith();
    t_daz();
    t_rerst();
    summarize();
  end
endmodule
